// ---- hdl/dnd_top.sv ----
`timescale 1ns/1ps
module dnd_top
  import dnd_pkg::*;
#(
  parameter logic [6:0] CARD_NUM  = DND_CARD_NUM,
  parameter logic [6:0] PRINT_NUM = DND_PRINT_NUM,
  parameter logic [6:0] PLOT_NUM  = DND_PLOT_NUM
) (
  // Clock and reset
  input  wire logic                             CLK,
  input  wire logic                             RST_N,
  // Bus selection lines, index 0 is bus bit 3
  input  wire logic [dnd_pkg::DND_NUM_BITS-1:0] SEL_TRUE,
  input  wire logic [dnd_pkg::DND_NUM_BITS-1:0] SEL_COMP,
  // Card reader straps
  input  wire logic                             CARD_OVERRIDE,
  input  wire logic [dnd_pkg::DND_NUM_BITS-1:0] CARD_JUMPER,
  input  wire logic                             CARD_DISABLE,
  // Line printer straps
  input  wire logic                             PRINT_OVERRIDE,
  input  wire logic [dnd_pkg::DND_NUM_BITS-1:0] PRINT_JUMPER,
  input  wire logic                             PRINT_DISABLE,
  // Plotter straps
  input  wire logic                             PLOT_OVERRIDE,
  input  wire logic [dnd_pkg::DND_NUM_BITS-1:0] PLOT_JUMPER,
  input  wire logic                             PLOT_DISABLE,
  // Selects
  output wire logic                             CARD_SELECT,
  output wire logic                             PRINT_SELECT,
  output wire logic                             PLOT_SELECT
);
  import dnd_pkg::*;

  // Selection pair stages
  logic [DND_NUM_BITS-1:0]  t_meta;
  logic [DND_NUM_BITS-1:0]  t_sync;
  logic [DND_NUM_BITS-1:0]  next_t_meta;
  logic [DND_NUM_BITS-1:0]  next_t_sync;
  logic [DND_NUM_BITS-1:0]  c_meta;
  logic [DND_NUM_BITS-1:0]  c_sync;
  logic [DND_NUM_BITS-1:0]  next_c_meta;
  logic [DND_NUM_BITS-1:0]  next_c_sync;

  // Strap stages, card in bit 0
  logic [DND_DEV_COUNT-1:0] ovr_meta;
  logic [DND_DEV_COUNT-1:0] ovr_sync;
  logic [DND_DEV_COUNT-1:0] next_ovr_meta;
  logic [DND_DEV_COUNT-1:0] next_ovr_sync;
  logic [DND_DEV_COUNT-1:0] dis_meta;
  logic [DND_DEV_COUNT-1:0] dis_sync;
  logic [DND_DEV_COUNT-1:0] next_dis_meta;
  logic [DND_DEV_COUNT-1:0] next_dis_sync;

  // Jumper stages
  logic [DND_NUM_BITS-1:0]  jmp_meta      [DND_DEV_COUNT];
  logic [DND_NUM_BITS-1:0]  jmp_sync      [DND_DEV_COUNT];
  logic [DND_NUM_BITS-1:0]  next_jmp_meta [DND_DEV_COUNT];
  logic [DND_NUM_BITS-1:0]  next_jmp_sync [DND_DEV_COUNT];

  // Number each comparator looks for, and its verdict
  logic [DND_NUM_BITS-1:0]  dflt          [DND_DEV_COUNT];
  logic [DND_NUM_BITS-1:0]  num           [DND_DEV_COUNT];
  logic [DND_DEV_COUNT-1:0] sel;

  // True lines come from the bus, another domain
  always_comb begin
    next_t_meta = SEL_TRUE;
    next_t_sync = t_meta;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      t_meta <= '0;
      t_sync <= '0;
    end else begin
      t_meta <= next_t_meta;
      t_sync <= next_t_sync;
    end
  end

  // Complement lines, same two stages
  always_comb begin
    next_c_meta = SEL_COMP;
    next_c_sync = c_meta;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      c_meta <= '0;
      c_sync <= '0;
    end else begin
      c_meta <= next_c_meta;
      c_sync <= next_c_sync;
    end
  end

  // Override straps
  always_comb begin
    next_ovr_meta = {PLOT_OVERRIDE, PRINT_OVERRIDE, CARD_OVERRIDE};
    next_ovr_sync = ovr_meta;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ovr_meta <= '0;
      ovr_sync <= '0;
    end else begin
      ovr_meta <= next_ovr_meta;
      ovr_sync <= next_ovr_sync;
    end
  end

  // Disable straps reset high so nothing selects before they settle
  always_comb begin
    next_dis_meta = {PLOT_DISABLE, PRINT_DISABLE, CARD_DISABLE};
    next_dis_sync = dis_meta;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      dis_meta <= '1;
      dis_sync <= '1;
    end else begin
      dis_meta <= next_dis_meta;
      dis_sync <= next_dis_sync;
    end
  end

  // Jumper numbers, one word per controller
  always_comb begin
    next_jmp_meta[DND_IDX_CARD]  = CARD_JUMPER;
    next_jmp_meta[DND_IDX_PRINT] = PRINT_JUMPER;
    next_jmp_meta[DND_IDX_PLOT]  = PLOT_JUMPER;
    next_jmp_sync[DND_IDX_CARD]  = jmp_meta[DND_IDX_CARD];
    next_jmp_sync[DND_IDX_PRINT] = jmp_meta[DND_IDX_PRINT];
    next_jmp_sync[DND_IDX_PLOT]  = jmp_meta[DND_IDX_PLOT];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      jmp_meta[DND_IDX_CARD]  <= '0;
      jmp_meta[DND_IDX_PRINT] <= '0;
      jmp_meta[DND_IDX_PLOT]  <= '0;
      jmp_sync[DND_IDX_CARD]  <= '0;
      jmp_sync[DND_IDX_PRINT] <= '0;
      jmp_sync[DND_IDX_PLOT]  <= '0;
    end else begin
      jmp_meta[DND_IDX_CARD]  <= next_jmp_meta[DND_IDX_CARD];
      jmp_meta[DND_IDX_PRINT] <= next_jmp_meta[DND_IDX_PRINT];
      jmp_meta[DND_IDX_PLOT]  <= next_jmp_meta[DND_IDX_PLOT];
      jmp_sync[DND_IDX_CARD]  <= next_jmp_sync[DND_IDX_CARD];
      jmp_sync[DND_IDX_PRINT] <= next_jmp_sync[DND_IDX_PRINT];
      jmp_sync[DND_IDX_PLOT]  <= next_jmp_sync[DND_IDX_PLOT];
    end
  end

  // Numbers used when no override is strapped
  always_comb begin
    dflt[DND_IDX_CARD]  = CARD_NUM;
    dflt[DND_IDX_PRINT] = PRINT_NUM;
    dflt[DND_IDX_PLOT]  = PLOT_NUM;
  end

  // Strapped number wins over the default
  always_comb begin
    for (int d = 0; d < DND_DEV_COUNT; d++) begin
      num[d] = ovr_sync[d] ? jmp_sync[d] : dflt[d];
    end
  end

  // Card reader comparator on the shared pairs
  dnd_match #(
    .N(DND_NUM_BITS)
  ) u_card_match (
    .clk        (CLK),
    .rst_n      (RST_N),
    .sel_true   (t_sync),
    .sel_comp   (c_sync),
    .number     (num[DND_IDX_CARD]),
    .disable_dec(dis_sync[DND_IDX_CARD]),
    .select     (sel[DND_IDX_CARD])
  );

  // Line printer comparator
  dnd_match #(
    .N(DND_NUM_BITS)
  ) u_print_match (
    .clk        (CLK),
    .rst_n      (RST_N),
    .sel_true   (t_sync),
    .sel_comp   (c_sync),
    .number     (num[DND_IDX_PRINT]),
    .disable_dec(dis_sync[DND_IDX_PRINT]),
    .select     (sel[DND_IDX_PRINT])
  );

  // Plotter comparator
  dnd_match #(
    .N(DND_NUM_BITS)
  ) u_plot_match (
    .clk        (CLK),
    .rst_n      (RST_N),
    .sel_true   (t_sync),
    .sel_comp   (c_sync),
    .number     (num[DND_IDX_PLOT]),
    .disable_dec(dis_sync[DND_IDX_PLOT]),
    .select     (sel[DND_IDX_PLOT])
  );

  // Selects leave straight from the comparator flops
  assign CARD_SELECT  = sel[DND_IDX_CARD];
  assign PRINT_SELECT = sel[DND_IDX_PRINT];
  assign PLOT_SELECT  = sel[DND_IDX_PLOT];
endmodule

// ---- hdl/dnd_pkg.sv ----
package dnd_pkg;
  localparam int          DND_NUM_BITS   = 7;
  localparam int          DND_DEV_COUNT  = 3;
  localparam int          DND_BUS_LO     = 3;
  localparam int          DND_BUS_HI     = 9;
  localparam logic [6:0]  DND_CARD_NUM   = 7'h54;
  localparam logic [6:0]  DND_PRINT_NUM  = 7'h0C;
  localparam logic [6:0]  DND_PLOT_NUM   = 7'h00;
  localparam int          DND_IDX_CARD   = 0;
  localparam int          DND_IDX_PRINT  = 1;
  localparam int          DND_IDX_PLOT   = 2;
endpackage

// ---- hdl/dnd_match.sv ----
`timescale 1ns/1ps
module dnd_match
  import dnd_pkg::*;
#(
  parameter int N = DND_NUM_BITS
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Synchronised selection pairs
  input  wire logic [N-1:0] sel_true,
  input  wire logic [N-1:0] sel_comp,
  // Jumper settings
  input  wire logic [N-1:0] number,
  input  wire logic         disable_dec,
  // Result
  output logic              select
);
  logic next_select;
  logic [N-1:0] bit_hit;

  always_comb begin
    // One line of each pair per bit, picked by the jumper
    for (int i = 0; i < N; i++) begin
      bit_hit[i] = number[i] ? sel_true[i] : sel_comp[i];
    end
    next_select = (&bit_hit) && !disable_dec;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      select <= 1'b0;
    end else begin
      select <= next_select;
    end
  end
endmodule

// ---- sim/dnd_top_chk.sv ----
`timescale 1ns/1ps
module dnd_top_chk
  import dnd_pkg::*;
(
  input wire logic       CLK, RST_N, CARD_OVERRIDE, CARD_DISABLE, PRINT_OVERRIDE, PRINT_DISABLE,
  input wire logic       PLOT_OVERRIDE, PLOT_DISABLE, CARD_SELECT, PRINT_SELECT, PLOT_SELECT,
  input wire logic [6:0] SEL_TRUE, SEL_COMP, CARD_JUMPER, PRINT_JUMPER, PLOT_JUMPER
);
  logic c, p, q;
  function automatic logic hit(logic [6:0] n, logic d);
    return !d && (SEL_TRUE & n | SEL_COMP & ~n) == 7'h7F;
  endfunction
  // Octal 124 and 140, bit 0 is bus bit 3
  always_comb begin
    c = hit(CARD_OVERRIDE ? CARD_JUMPER : 7'h54, CARD_DISABLE);
    p = hit(PRINT_OVERRIDE ? PRINT_JUMPER : 7'h0C, PRINT_DISABLE);
    q = hit(PLOT_OVERRIDE ? PLOT_JUMPER : DND_PLOT_NUM, PLOT_DISABLE);
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_card_hit: assert property (c [*4] |-> CARD_SELECT) else $error("card miss");
  a_card_stray: assert property (!c [*4] |-> !CARD_SELECT) else $error("card stray");
  a_print_hit: assert property (p [*4] |-> PRINT_SELECT) else $error("print miss");
  a_print_stray: assert property (!p [*4] |-> !PRINT_SELECT) else $error("print stray");
  a_plot_hit: assert property (q [*4] |-> PLOT_SELECT) else $error("plot miss");
  a_plot_stray: assert property (!q [*4] |-> !PLOT_SELECT) else $error("plot stray");
  a_card_off: assert property (CARD_DISABLE [*4] |-> !CARD_SELECT) else $error("card off");
endmodule
bind dnd_top dnd_top_chk u_chk (.*);

// ---- sim/dnd_cpu.sv ----
`timescale 1ns/1ps
module dnd_cpu (
  input  wire logic       go,
  input  wire logic [6:0] num,
  output wire logic [6:0] st,
  output wire logic [6:0] sc
);
  // Idle leaves both lines of every pair low
  assign st = go ? num : 7'h00;
  assign sc = go ? ~num : 7'h00;
endmodule

// ---- sim/dnd_top_bench.sv ----
`timescale 1ns/1ps
`define CHK(e, s) begin cmp_count++; if ((e) !== (s)) begin n_fail++; $display("mismatch select %b %b", e, s); end end
module dnd_top_bench;
  logic       clk = 0, rst_n = 0, go = 0;
  logic [6:0] n = 7'h00, st, sc, j[3] = '{7'h00, 7'h00, 7'h00}, d[3];
  logic [2:0] o = 3'h0, x = 3'h0, s;
  logic [31:0] r = 32'h55E12E6C;
  int         n_fail = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [6:0] oct(logic [8:0] v);
    for (int i = 0; i < 7; i++) oct[i] = v[8 - i];
  endfunction
  dnd_cpu u_cpu (.go(go), .num(n), .st(st), .sc(sc));
  dnd_top u_dut (.CLK(clk), .RST_N(rst_n), .SEL_TRUE(st), .SEL_COMP(sc), .CARD_OVERRIDE(o[0]), .CARD_JUMPER(j[0]),
    .CARD_DISABLE(x[0]), .PRINT_OVERRIDE(o[1]), .PRINT_JUMPER(j[1]), .PRINT_DISABLE(x[1]), .PLOT_OVERRIDE(o[2]),
    .PLOT_JUMPER(j[2]), .PLOT_DISABLE(x[2]), .CARD_SELECT(s[0]), .PRINT_SELECT(s[1]), .PLOT_SELECT(s[2]));
  task stop_test;
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task run(logic [6:0] v, logic g);
    @(negedge clk);
    n = v;
    go = g;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 3; i++) `CHK(g && !x[i] && (o[i] ? j[i] : d[i]) === v, s[i])
  endtask
  initial begin
    d = '{oct(9'h054), oct(9'h060), 7'h00};
    repeat (6) @(negedge clk);
    rst_n = 1;
    run(d[0], 1);
    run(d[1], 1);
    run(7'h00, 1);
    run(d[0], 0);
    x = 3'h7;
    run(d[0], 1);
    repeat (80) begin
      r = nx(r);
      {x, o, j[0], j[1], j[2]} = {r[4:2] & r[7:5], r[10:8], r[31:11]};
      r = nx(r);
      run((r[1:0] == 3 ? r[8:2] : j[r[1:0]]) ^ (r[9] ? 7'h01 << r[12:10] : 7'h00), 1);
    end
    stop_test;
  end
endmodule
